/* File: core/dce_defs.svh */
// Command codes, control bit positions and fixed values of the debug engine
`ifndef DCE_DEFS_SVH
`define DCE_DEFS_SVH
`define DCE_CMD_RD_STAT 8'h02
`define DCE_CMD_WR_CTL 8'h04
`define DCE_CMD_RD_CTL 8'h05
`define DCE_CMD_WR_PM 8'h0A
`define DCE_CMD_RD_PM 8'h0B
`define DCE_CMD_WR_DM 8'h0C
`define DCE_CMD_RD_DM 8'h0D
`define DCE_CMD_CRC 8'h0E
`define DCE_CMD_STEP 8'h10
`define DCE_CMD_STUFF 8'h11
`define DCE_CMD_EXEC 8'h12
`define DCE_FILL_BYTE 8'hFF
`define DCE_CRC_FILL 16'hFFFF
`define DCE_CRC_INIT 16'hFFFF
`define DCE_CRC_POLY 16'h1021
`define DCE_CTL_RESET 8'h00
`define DCE_CTL_WMASK 8'hF1
`define DCE_BIT_DBG 7
`define DCE_BIT_BREAKPOINT_ENABLE_BIT 6
`define DCE_BIT_ACK 5
`define DCE_BIT_LOOP 4
`define DCE_BIT_RST 0
`define DCE_PM_BYTES 65536
`endif

/* File: core/dce_pkg.sv */
// Types shared by the debug command engine and its users
package dce_pkg;
    typedef enum logic [3:0] {
        DCE_ST_IDLE = 4'h0,
        DCE_ST_ADDR_H = 4'h1,
        DCE_ST_ADDR_L = 4'h3,
        DCE_ST_SIZE_H = 4'h2,
        DCE_ST_SIZE_L = 4'h6,
        DCE_ST_DATA = 4'h7,
        DCE_ST_CRC = 4'h5,
        DCE_ST_CRC_TX = 4'h4,
        DCE_ST_RESP = 4'hC,
        DCE_ST_WCTL = 4'hD,
        DCE_ST_STUFF = 4'hF,
        DCE_ST_EXEC_OP = 4'hE,
        DCE_ST_EXEC_LEN = 4'hA,
        DCE_ST_EXEC_BYTES = 4'hB
    } dce_state_type;

    typedef struct packed {
        logic re;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dce_mem_req_type;

    typedef struct packed {
        logic step;
        logic stuff;
        logic exec;
        logic [7:0] opcode;
        logic [4:0][7:0] ibuf;
    } dce_cpu_cmd_type;

    typedef struct packed {
        dce_state_type state;
        logic [7:0] ctl;
        logic brk_seen;
        logic ack_pend;
        logic [7:0] cmd;
        logic [7:0] resp;
        logic [15:0] addr;
        logic [16:0] count;
        logic rd_wait;
        logic tx_valid;
        logic [7:0] tx_data;
        logic [15:0] crc;
        logic [2:0] ilen;
        logic [2:0] icnt;
        dce_mem_req_type pm;
        dce_mem_req_type dm;
        dce_cpu_cmd_type cpu;
    } dce_regs_type;
endpackage

/* File: core/dce_engine.sv */
// Debug command engine: host byte commands to memories, CPU and control
`timescale 1ns/1ps
`include "dce_defs.svh"

// Operation
// R1 - Program write: cmd, address, size, data
// R2 - Drop program writes unless flash unlocked
// R3 - Program read returns FFH when gated
// R4 - Data write framed alike, gated drops
// R5 - Data read FFH only outside debug
// R6 - CRC-CCITT over program memory, FFFFH gated
// R7 - CRC answer comes after memory sweep
// R8 - Step one instruction when allowed
// R9 - Stuff host opcode, rest from memory
// R10 - Execute host instruction of 1-5 bytes
// R11 - 81H reset-stop, 41H reset-go, 40H run
// R12 - Debug bit halts fetch, resets zero
// R13 - Read protect forbids clearing debug bit
// R14 - Breakpoint enable gates breakpoint opcode
// R15 - Breakpoint halts, or CPU spins
// R16 - Send FFH on breakpoint if enabled
// R17 - Control bit 0 resets device, self-clears
// R18 - Host writes reserved bits as zero
// R19 - Status bit 7: halted or breakpoint seen
// R20 - Status: halt mode, protect, zeros
// R21 - Host waits for full previous response
module dce_engine #(
    parameter int PM_BYTES = `DCE_PM_BYTES // Program memory size
) (
    input wire logic i_clock,                 // System clock
    input wire logic i_arst_n,                // Async reset, active low
    input wire logic i_rx_valid,              // Host byte present
    input wire logic [7:0] i_rx_data,         // Host byte
    output logic o_tx_valid,                  // Byte for host
    output logic [7:0] o_tx_data,             // Byte value for host
    input wire logic i_tx_ready,              // Link takes byte
    output dce_pkg::dce_mem_req_type o_pm,    // Program memory request
    input wire logic [7:0] i_pm_rdata,        // Program read data
    output dce_pkg::dce_mem_req_type o_dm,    // Data memory request
    input wire logic [7:0] i_dm_rdata,        // Data read data
    input wire logic i_flash_unlocked,        // Flash controller unlocked
    input wire logic i_rp_option,             // Protect option, 0 active
    input wire logic i_cpu_brk,               // Breakpoint opcode decoded
    input wire logic i_cpu_halt_mode,         // CPU in halt mode
    input wire logic [2:0] i_cpu_ilen,        // Length of o_cpu.opcode
    input wire logic i_reset_done,            // Device reset finished
    output dce_pkg::dce_cpu_cmd_type o_cpu,   // Step, stuff, execute
    output logic o_cpu_halt,                  // Stop instruction fetch
    output logic o_brk_enable,                // Breakpoint opcode active
    output logic o_brk_spin,                  // Spin on breakpoint
    output logic o_sys_reset                  // Device reset request
);
    import dce_pkg::*;

    dce_regs_type r;
    dce_regs_type next_r;
    logic dbg;
    logic rp;
    logic ok;
    logic [7:0] status;
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] x;
        x = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            x = x[15] ? ({x[14:0], 1'b0} ^ `DCE_CRC_POLY)
                      : {x[14:0], 1'b0};
        end
        return x;
    endfunction

    assign dbg = r.ctl[`DCE_BIT_DBG];
    assign rp = ~i_rp_option;
    assign ok = dbg && !rp;
    // R19 R20 status layout
    assign status = {dbg | r.brk_seen, i_cpu_halt_mode, rp, 5'h00};

    always_comb begin
        next_r = r;
        next_r.pm.re = 1'b0;
        next_r.pm.we = 1'b0;
        next_r.dm.re = 1'b0;
        next_r.dm.we = 1'b0;
        next_r.cpu.step = 1'b0;
        next_r.cpu.stuff = 1'b0;
        next_r.cpu.exec = 1'b0;
        if (r.tx_valid && i_tx_ready) begin
            next_r.tx_valid = 1'b0;
        end
        // R17 reset bit self-clears
        if (r.ctl[`DCE_BIT_RST] && i_reset_done) begin
            next_r.ctl[`DCE_BIT_RST] = 1'b0;
        end
        unique case (r.state)
            DCE_ST_IDLE: begin
                if (i_rx_valid) begin
                    next_r.cmd = i_rx_data;
                    case (i_rx_data)
                        `DCE_CMD_RD_STAT: begin
                            next_r.resp = status;
                            next_r.state = DCE_ST_RESP;
                        end
                        `DCE_CMD_RD_CTL: begin
                            next_r.resp = r.ctl;
                            next_r.state = DCE_ST_RESP;
                        end
                        `DCE_CMD_WR_CTL: next_r.state = DCE_ST_WCTL;
                        `DCE_CMD_WR_PM, `DCE_CMD_RD_PM,
                        `DCE_CMD_WR_DM, `DCE_CMD_RD_DM: begin
                            next_r.state = DCE_ST_ADDR_H;
                        end
                        // R6 gated CRC answer
                        `DCE_CMD_CRC: begin
                            next_r.addr = 16'h0000;
                            next_r.count = 17'(PM_BYTES);
                            next_r.rd_wait = 1'b0;
                            next_r.icnt = 3'h0;
                            next_r.crc = dbg ? `DCE_CRC_INIT
                                             : `DCE_CRC_FILL;
                            next_r.state = dbg ? DCE_ST_CRC
                                               : DCE_ST_CRC_TX;
                        end
                        // R8 step when allowed
                        `DCE_CMD_STEP: next_r.cpu.step = ok;
                        `DCE_CMD_STUFF: next_r.state = DCE_ST_STUFF;
                        `DCE_CMD_EXEC: next_r.state = DCE_ST_EXEC_OP;
                        default: ;
                    endcase
                end else if (r.ack_pend && !r.tx_valid) begin
                    // R16 breakpoint acknowledge
                    next_r.ack_pend = 1'b0;
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data = `DCE_FILL_BYTE;
                end
            end
            // R1 address and size framing
            DCE_ST_ADDR_H: begin
                if (i_rx_valid) begin
                    next_r.addr[15:8] = i_rx_data;
                    next_r.state = DCE_ST_ADDR_L;
                end
            end
            DCE_ST_ADDR_L: begin
                if (i_rx_valid) begin
                    next_r.addr[7:0] = i_rx_data;
                    next_r.state = DCE_ST_SIZE_H;
                end
            end
            DCE_ST_SIZE_H: begin
                if (i_rx_valid) begin
                    next_r.count = {1'b0, i_rx_data, 8'h00};
                    next_r.state = DCE_ST_SIZE_L;
                end
            end
            DCE_ST_SIZE_L: begin
                if (i_rx_valid) begin
                    // Size zero stands for 65536 bytes
                    next_r.count = {r.count[15:8] == 8'h00
                                    && i_rx_data == 8'h00,
                                    r.count[15:8], i_rx_data};
                    next_r.rd_wait = 1'b0;
                    next_r.state = DCE_ST_DATA;
                end
            end
            DCE_ST_DATA: begin
                if (r.cmd == `DCE_CMD_WR_PM || r.cmd == `DCE_CMD_WR_DM) begin
                    if (i_rx_valid) begin
                        // R2 flash must be unlocked
                        next_r.pm.we = r.cmd == `DCE_CMD_WR_PM
                                       && ok && i_flash_unlocked;
                        // R4 gated data writes
                        next_r.dm.we = r.cmd == `DCE_CMD_WR_DM && ok;
                        next_r.pm.addr = r.addr;
                        next_r.dm.addr = r.addr;
                        next_r.pm.wdata = i_rx_data;
                        next_r.dm.wdata = i_rx_data;
                        next_r.addr = r.addr + 16'h0001;
                        next_r.count = r.count - 17'h00001;
                        if (r.count == 17'h00001) begin
                            next_r.state = DCE_ST_IDLE;
                        end
                    end
                end else if (r.rd_wait) begin
                    next_r.rd_wait = 1'b0;
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data = r.cmd == `DCE_CMD_RD_PM ? i_pm_rdata
                                                             : i_dm_rdata;
                    next_r.addr = r.addr + 16'h0001;
                    next_r.count = r.count - 17'h00001;
                    if (r.count == 17'h00001) begin
                        next_r.state = DCE_ST_IDLE;
                    end
                end else if (!r.tx_valid) begin
                    // R3 R5 read gates
                    if (r.cmd == `DCE_CMD_RD_PM ? !ok : !dbg) begin
                        next_r.tx_valid = 1'b1;
                        next_r.tx_data = `DCE_FILL_BYTE;
                        next_r.count = r.count - 17'h00001;
                        if (r.count == 17'h00001) begin
                            next_r.state = DCE_ST_IDLE;
                        end
                    end else begin
                        next_r.pm.re = r.cmd == `DCE_CMD_RD_PM;
                        next_r.dm.re = r.cmd == `DCE_CMD_RD_DM;
                        next_r.pm.addr = r.addr;
                        next_r.dm.addr = r.addr;
                        next_r.rd_wait = 1'b1;
                    end
                end
            end
            // R7 one byte per cycle sweep
            DCE_ST_CRC: begin
                if (r.rd_wait) begin
                    next_r.crc = crc_byte(r.crc, i_pm_rdata);
                end
                next_r.rd_wait = r.count != 17'h00000;
                if (r.count != 17'h00000) begin
                    next_r.pm.re = 1'b1;
                    next_r.pm.addr = r.addr;
                    next_r.addr = r.addr + 16'h0001;
                    next_r.count = r.count - 17'h00001;
                end else if (!r.rd_wait) begin
                    next_r.state = DCE_ST_CRC_TX;
                end
            end
            DCE_ST_CRC_TX: begin
                if (!r.tx_valid) begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data = r.icnt[0] ? r.crc[7:0] : r.crc[15:8];
                    next_r.icnt = 3'h1;
                    if (r.icnt[0]) begin
                        next_r.state = DCE_ST_IDLE;
                    end
                end
            end
            DCE_ST_RESP: begin
                if (!r.tx_valid) begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data = r.resp;
                    next_r.state = DCE_ST_IDLE;
                end
            end
            DCE_ST_WCTL: begin
                if (i_rx_valid) begin
                    // R11 R12 control write
                    next_r.ctl = (i_rx_data & `DCE_CTL_WMASK)
                                 | {7'h00, next_r.ctl[`DCE_BIT_RST]};
                    // R13 protected debug bit sticks
                    if (rp && dbg) begin
                        next_r.ctl[`DCE_BIT_DBG] = 1'b1;
                    end
                    next_r.brk_seen = 1'b0;
                    next_r.state = DCE_ST_IDLE;
                end
            end
            // R9 stuff first opcode byte
            DCE_ST_STUFF: begin
                if (i_rx_valid) begin
                    next_r.cpu.opcode = i_rx_data;
                    next_r.cpu.stuff = ok;
                    next_r.state = DCE_ST_IDLE;
                end
            end
            // R10 collect whole instruction
            DCE_ST_EXEC_OP: begin
                if (i_rx_valid) begin
                    next_r.cpu.opcode = i_rx_data;
                    next_r.cpu.ibuf = '0;
                    next_r.cpu.ibuf[0] = i_rx_data;
                    next_r.icnt = 3'h1;
                    next_r.state = DCE_ST_EXEC_LEN;
                end
            end
            DCE_ST_EXEC_LEN: begin
                next_r.ilen = i_cpu_ilen;
                if (i_cpu_ilen <= 3'h1) begin
                    next_r.cpu.exec = ok;
                    next_r.state = DCE_ST_IDLE;
                end else begin
                    next_r.state = DCE_ST_EXEC_BYTES;
                end
            end
            DCE_ST_EXEC_BYTES: begin
                if (i_rx_valid) begin
                    next_r.cpu.ibuf[r.icnt] = i_rx_data;
                    next_r.icnt = r.icnt + 3'h1;
                    if (r.icnt + 3'h1 >= r.ilen || r.icnt == 3'h4) begin
                        next_r.cpu.exec = ok;
                        next_r.state = DCE_ST_IDLE;
                    end
                end
            end
            default: next_r.state = DCE_ST_IDLE;
        endcase
        // R14 breakpoint only when enabled
        if (i_cpu_brk && r.ctl[`DCE_BIT_BREAKPOINT_ENABLE_BIT]) begin
            next_r.brk_seen = 1'b1;
            // R15 halt unless spinning
            if (!r.ctl[`DCE_BIT_LOOP]) begin
                next_r.ctl[`DCE_BIT_DBG] = 1'b1;
            end
            if (r.ctl[`DCE_BIT_ACK]) begin
                next_r.ack_pend = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_tx_valid = r.tx_valid;
    assign o_tx_data = r.tx_data;
    assign o_pm = r.pm;
    assign o_dm = r.dm;
    assign o_cpu = r.cpu;
    assign o_cpu_halt = r.ctl[`DCE_BIT_DBG];
    assign o_brk_enable = r.ctl[`DCE_BIT_BREAKPOINT_ENABLE_BIT];
    assign o_brk_spin = r.ctl[`DCE_BIT_LOOP];
    assign o_sys_reset = r.ctl[`DCE_BIT_RST];

    AST_PM_WR_GATE: assert property ( // R2
        @(posedge i_clock) disable iff (!i_arst_n)
        r.pm.we |-> $past(i_flash_unlocked && ok))
        else $error("program write while locked or gated");
    AST_PM_RD_FILL: assert property ( // R3
        @(posedge i_clock) disable iff (!i_arst_n)
        (r.state == DCE_ST_DATA && r.cmd == `DCE_CMD_RD_PM && !ok
         && !r.rd_wait && !r.tx_valid)
        |=> r.tx_valid && r.tx_data == `DCE_FILL_BYTE && !r.pm.re)
        else $error("gated program read did not return FFH");
    AST_DM_WR_GATE: assert property ( // R4
        @(posedge i_clock) disable iff (!i_arst_n)
        r.dm.we |-> $past(ok))
        else $error("data write while gated");
    AST_DM_RD_PROT: assert property ( // R5
        @(posedge i_clock) disable iff (!i_arst_n)
        (r.state == DCE_ST_DATA && r.cmd == `DCE_CMD_RD_DM && dbg
         && !r.rd_wait && !r.tx_valid) |=> r.dm.re ##1 r.tx_valid)
        else $error("data read blocked in debug mode");
    AST_CRC_FILL: assert property ( // R6
        @(posedge i_clock) disable iff (!i_arst_n)
        (r.state == DCE_ST_IDLE && i_rx_valid
         && i_rx_data == `DCE_CMD_CRC && !dbg)
        |=> r.state == DCE_ST_CRC_TX && r.crc == `DCE_CRC_FILL)
        else $error("CRC outside debug mode not FFFFH");
    AST_STEP_GATE: assert property ( // R8
        @(posedge i_clock) disable iff (!i_arst_n)
        (r.cpu.step || r.cpu.stuff || r.cpu.exec) |-> $past(ok))
        else $error("instruction issued while gated");
    AST_RP_HOLD: assert property ( // R13
        @(posedge i_clock) disable iff (!i_arst_n)
        (rp && dbg) |=> r.ctl[`DCE_BIT_DBG])
        else $error("debug bit cleared under read protect");
    AST_BRK_HALT: assert property ( // R15
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_cpu_brk && r.ctl[`DCE_BIT_BREAKPOINT_ENABLE_BIT] && !r.ctl[`DCE_BIT_LOOP])
        |=> o_cpu_halt && status[7])
        else $error("enabled breakpoint did not halt");
    AST_BRK_ACK: assert property ( // R16
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_cpu_brk && r.ctl[`DCE_BIT_BREAKPOINT_ENABLE_BIT] && r.ctl[`DCE_BIT_ACK])
        |=> r.ack_pend)
        else $error("breakpoint acknowledge not queued");
endmodule

/* File: testbench/dce_host_model.sv */
// Host debugger model: sends command bytes and takes answer bytes
`timescale 1ns/1ps
module dce_host_model (
    input wire logic i_clock,         // System clock
    output logic o_rx_valid,          // Byte to engine
    output logic [7:0] o_rx_data,     // Byte value to engine
    input wire logic i_tx_valid,      // Engine byte present
    input wire logic [7:0] i_tx_data, // Engine byte value
    output logic o_tx_ready           // Host takes engine byte
);
    int stall = 0;

    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_tx_ready = 1'b0;
    end

    // one byte per pulse, framed by caller
    task automatic send(input logic [7:0] b);
        @(posedge i_clock);
        #1;
        o_rx_valid = 1'b1;
        o_rx_data = b;
        @(posedge i_clock);
        #1;
        o_rx_valid = 1'b0;
        o_rx_data = ~b;
    endtask

    // wait for one answer byte, bounded
    task automatic recv(output logic [7:0] b, input int lim);
        int n;
        n = 0;
        b = 8'hXX;
        while (i_tx_valid !== 1'b1 && n < lim) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (i_tx_valid === 1'b1) begin
            repeat (stall) @(posedge i_clock);
            #1;
            o_tx_ready = 1'b1;
            @(posedge i_clock);
            b = i_tx_data;
            #1;
            o_tx_ready = 1'b0;
        end
    endtask
endmodule

/* File: testbench/tb.sv */
// Self-checking bench of the debug command engine and its host model
`timescale 1ns/1ps
`include "dce_defs.svh"
module tb;
    import dce_pkg::*;
    localparam int PMB = 16;
    logic i_clock, i_arst_n, txv;
    logic rxv;
    logic txr;
    logic unl;
    logic rpo;
    logic breakpoint_opcode;
    logic hlt;
    logic rdn;
    logic cpu_halt, brk_en, brk_spin, sys_rst;
    logic [7:0] txd, b;
    logic [7:0] rxd;
    logic [7:0] pmr;
    logic [7:0] dmr;
    logic [2:0] ilen;
    dce_mem_req_type pm, dm;
    dce_cpu_cmd_type cpu;
    logic [7:0] pmem [PMB];
    logic [7:0] dmem [256];
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_pw = 0, n_dw = 0, n_st = 0, n_sf = 0, n_ex = 0;

    dce_engine #(.PM_BYTES(PMB)) i_dut (
        .i_clock(i_clock), .i_arst_n(i_arst_n), .i_rx_valid(rxv),
        .i_rx_data(rxd), .o_tx_valid(txv), .o_tx_data(txd),
        .i_tx_ready(txr), .o_pm(pm), .i_pm_rdata(pmr), .o_dm(dm),
        .i_dm_rdata(dmr), .i_flash_unlocked(unl), .i_rp_option(rpo),
        .i_cpu_brk(breakpoint_opcode), .i_cpu_halt_mode(hlt), .i_cpu_ilen(ilen),
        .i_reset_done(rdn), .o_cpu(cpu), .o_cpu_halt(cpu_halt),
        .o_brk_enable(brk_en), .o_brk_spin(brk_spin), .o_sys_reset(sys_rst)
    );
    dce_host_model i_host (
        .i_clock(i_clock), .o_rx_valid(rxv), .o_rx_data(rxd),
        .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr)
    );

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Memories answer while the read strobe stands, junk otherwise
    assign pmr = pm.re ? pmem[pm.addr[3:0]] : 8'hEE;
    assign dmr = dm.re ? dmem[dm.addr[7:0]] : 8'hEE;
    always @(posedge i_clock) begin
        if (pm.we) pmem[pm.addr[3:0]] <= pm.wdata;
        if (dm.we) dmem[dm.addr[7:0]] <= dm.wdata;
        n_pw += int'(pm.we);
        n_dw += int'(dm.we);
        n_st += int'(cpu.step);
        n_sf += int'(cpu.stuff);
        n_ex += int'(cpu.exec);
        rdn <= sys_rst;
    end

    function automatic logic [15:0] crc_pm();
        logic [15:0] c;
        c = `DCE_CRC_INIT;
        for (int i = 0; i < PMB; i++) begin
            c ^= {pmem[i], 8'h00};
            for (int k = 0; k < 8; k++)
                c = c[15] ? ((c << 1) ^ `DCE_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic hdr(input logic [7:0] c, input logic [15:0] a,
                       input logic [15:0] n);
        logic [31:0] w;
        w = {a, n};
        i_host.send(c);
        for (int i = 3; i >= 0; i--) i_host.send(w[i*8 +: 8]);
    endtask

    task automatic take(input string s, input logic [7:0] e);
        i_host.recv(b, 400);
        chk(s, 16'(e), 16'(b));
    endtask

    task automatic rd(input logic [7:0] c, input string s,
                      input logic [7:0] e);
        i_host.send(c);
        take(s, e);
    endtask

    task automatic wctl(input logic [7:0] v);
        i_host.send(`DCE_CMD_WR_CTL);
        i_host.send(v);
    endtask

    task automatic gap();
        repeat (3) @(posedge i_clock);
        #1;
    endtask

    task automatic bp();
        @(posedge i_clock);
        #1 breakpoint_opcode = 1'b1;
        @(posedge i_clock);
        #1 breakpoint_opcode = 1'b0;
    endtask

    task automatic t_reset();
        chk("halt out", 16'h0000, 16'(cpu_halt));
        rd(`DCE_CMD_RD_CTL, "ctl reset", 8'h00);
        rd(`DCE_CMD_RD_STAT, "stat reset", 8'h00);
    endtask

    task automatic t_gated();
        i_host.send(`DCE_CMD_STEP);
        hdr(`DCE_CMD_RD_PM, 16'h0002, 16'h0002);
        take("pm gated", 8'hFF);
        take("pm gated", 8'hFF);
        hdr(`DCE_CMD_RD_DM, 16'h0020, 16'h0001);
        take("dm gated", 8'hFF);
        rd(`DCE_CMD_CRC, "crc hi gated", 8'hFF);
        take("crc lo gated", 8'hFF);
        hdr(`DCE_CMD_WR_DM, 16'h0020, 16'h0001);
        i_host.send(8'h5A);
        gap();
        chk("gated counts", 16'h0000, {8'(n_st), 8'(n_dw)});
    endtask

    task automatic t_debug();
        logic [7:0] v [2] = '{8'h41, 8'h81};
        int n;
        for (int i = 0; i < 2; i++) begin
            wctl(v[i]);
            n = 0;
            while (sys_rst !== 1'b1 && n < 10) begin
                @(posedge i_clock);
                #1;
                n++;
            end
            chk("sys reset", 16'h0001, 16'(sys_rst));
            gap();
            rd(`DCE_CMD_RD_CTL, "ctl", {v[i][7:1], 1'b0});
            chk("halt out", 16'(v[i][7]), 16'(cpu_halt));
        end
        hlt = 1'b1;
        rd(`DCE_CMD_RD_STAT, "stat halt", 8'hC0);
        hlt = 1'b0;
    endtask

    task automatic t_mem();
        hdr(`DCE_CMD_WR_PM, 16'h0003, 16'h0001);
        i_host.send(8'hA5);
        unl = 1'b1;
        hdr(`DCE_CMD_WR_PM, 16'h0004, 16'h0002);
        i_host.send(8'h11);
        i_host.send(8'h22);
        hdr(`DCE_CMD_RD_PM, 16'h0003, 16'h0003);
        i_host.stall = 3;
        take("pm 3", 8'hC3);
        take("pm 4", 8'h11);
        take("pm 5", 8'h22);
        i_host.stall = 0;
        hdr(`DCE_CMD_WR_DM, 16'h0020, 16'h0002);
        i_host.send(8'h33);
        i_host.send(8'h44);
        hdr(`DCE_CMD_RD_DM, 16'h0020, 16'h0002);
        take("dm 20", 8'h33);
        take("dm 21", 8'h44);
        chk("pm writes", 16'h0002, 16'(n_pw));
    endtask

    task automatic t_crc();
        logic [15:0] e;
        time t0;
        e = crc_pm();
        t0 = $time;
        rd(`DCE_CMD_CRC, "crc hi", e[15:8]);
        chk("crc wait", 16'h0001, 16'(($time - t0) >= PMB * 10));
        take("crc lo", e[7:0]);
    endtask

    task automatic t_cpu();
        ilen = 3'h3;
        i_host.send(`DCE_CMD_STEP);
        i_host.send(`DCE_CMD_STUFF);
        i_host.send(8'h3C);
        gap();
        chk("stuff op", 16'h003C, 16'(cpu.opcode));
        i_host.send(`DCE_CMD_EXEC);
        i_host.send(8'hA1);
        i_host.send(8'hB2);
        i_host.send(8'hC3);
        gap();
        chk("exec bytes", 16'hA1C3, {cpu.ibuf[0], cpu.ibuf[2]});
        chk("cpu counts", 16'h0111, 12'({4'(n_st), 4'(n_sf), 4'(n_ex)}));
    endtask

    task automatic t_brk();
        wctl(8'h40);
        rd(`DCE_CMD_RD_CTL, "ctl run", 8'h40);
        chk("run", 16'h0001, 16'({cpu_halt, brk_en}));
        wctl(8'h00);
        bp();
        gap();
        chk("brk off", 16'h0000, 16'(cpu_halt));
        wctl(8'h60);
        bp();
        take("brk ack", 8'hFF);
        chk("brk halts", 16'h0001, 16'(cpu_halt));
        rd(`DCE_CMD_RD_STAT, "stat brk", 8'h80);
        wctl(8'h50);
        bp();
        gap();
        chk("spin", 16'h0001, 16'({cpu_halt, brk_spin}));
        rd(`DCE_CMD_RD_STAT, "stat spin", 8'h80);
        wctl(8'h10);
        rd(`DCE_CMD_RD_STAT, "stat clear", 8'h00);
    endtask

    task automatic t_protect();
        rpo = 1'b0;
        wctl(8'h80);
        rd(`DCE_CMD_RD_STAT, "stat prot", 8'hA0);
        i_host.send(`DCE_CMD_STEP);
        hdr(`DCE_CMD_RD_PM, 16'h0004, 16'h0001);
        take("pm prot", 8'hFF);
        hdr(`DCE_CMD_RD_DM, 16'h0021, 16'h0001);
        take("dm prot", 8'h44);
        hdr(`DCE_CMD_WR_DM, 16'h0021, 16'h0001);
        i_host.send(8'h55);
        wctl(8'h00);
        rd(`DCE_CMD_RD_CTL, "ctl prot", 8'h80);
        chk("prot counts", 16'h0102, {8'(n_st), 8'(n_dw)});
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        i_arst_n = 1'b0;
        {unl, breakpoint_opcode, hlt} = 3'h0;
        rpo = 1'b1;
        ilen = 3'h1;
        for (int i = 0; i < PMB; i++) pmem[i] = 8'hC0 + 8'(i);
        repeat (10) @(posedge i_clock);
        #1 i_arst_n = 1'b1;
        t_reset();
        t_gated();
        t_debug();
        t_mem();
        t_crc();
        t_cpu();
        t_brk();
        t_protect();
        wrap_up();
    end

    initial begin
        #100000;
        n_mismatch++;
        $display("Watchdog expired");
        wrap_up();
    end
endmodule
